/* rtl/sppm_pkg.sv */
// Constants and types shared by the serial/parallel power and mode configuration bank
package sppm_pkg;
    // Avalon byte addresses of the bus-facing registers
    localparam logic [4:0] ADDR_INDEX = 5'h00;
    localparam logic [4:0] ADDR_DATA = 5'h04;
    localparam logic [4:0] ADDR_CTRL = 5'h08;
    localparam logic [4:0] ADDR_LOCK_MODE = 5'h0C;
    localparam logic [4:0] ADDR_BASE1 = 5'h10;
    localparam logic [4:0] ADDR_BASE2 = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;

    // Index values loaded into config_select_index
    localparam logic [7:0] IDX_SERIAL_PORT_POWER = 8'h02;
    localparam logic [7:0] IDX_VENDOR_RESERVED_THREE = 8'h03;
    localparam logic [7:0] IDX_PARALLEL_SERIAL_MISC = 8'h04;

    // Power-on reset values
    localparam logic [7:0] RST_SERIAL_PORT_POWER = 8'h08;
    localparam logic [7:0] RST_VENDOR_RESERVED_THREE = 8'h70;
    localparam logic [7:0] RST_PARALLEL_SERIAL_MISC = 8'h00;
    localparam logic [7:0] RST_LOCK_MODE = 8'h88;
    localparam logic [15:0] RST_BASE = 16'h0000;

    // Writable bit masks; all other positions read zero
    localparam logic [7:0] MASK_SERIAL_PORT_POWER = 8'h88;
    localparam logic [7:0] MASK_VENDOR_RESERVED_THREE = 8'h72;
    localparam logic [7:0] MASK_PARALLEL_SERIAL_MISC = 8'h7F;
    localparam logic [7:0] MASK_LOCK_MODE = 8'h88;

    // Field positions
    localparam int BIT_PORT1_POWER = 3;
    localparam int BIT_PORT2_POWER = 7;
    localparam int BIT_PORT1_MUSIC = 4;
    localparam int BIT_PORT2_MUSIC = 5;
    localparam int BIT_EPP_REVISION = 6;
    localparam int BIT_PRINTER_MODE = 3;
    localparam int BIT_LOCK = 7;
    localparam int BIT_CFG_ACTIVE = 0;

    // Lowest base address that keeps host decoding alive
    localparam logic [15:0] MIN_DECODE_BASE = 16'h0100;

    // Extended control register modes
    localparam logic [2:0] ECR_MODE_SPP = 3'h0;
    localparam logic [2:0] ECR_MODE_EPP = 3'h4;

    // Music clock: 31.25 kbaud with 16x oversampling from a 50 MHz clock
    localparam int CLK_HZ = 50000000;
    localparam int MUSIC_BAUD = 31250;
    localparam int OVERSAMPLE = 16;
    localparam int MUSIC_TICK_CYCLES = CLK_HZ / (MUSIC_BAUD * OVERSAMPLE);

    // Effective parallel port mode
    typedef enum logic [2:0] {
        PAR_PRINTER,
        PAR_SPP,
        PAR_EPP_SPP,
        PAR_ECP,
        PAR_ECP_EPP
    } sppm_par_mode_t;
endpackage : sppm_pkg

/* rtl/sppm_config.sv */
// Indexed power and mode configuration bank behind an Avalon-MM slave
// Functional notes
// - Access only in config state, matching index
// - Power reg resets 0x08; hard reset clears bit7
// - Bit3 high runs port1, low powers down
// - Bit7 powers port2 and fast infrared engine
// - Power reg bits 0-2,4-6 read zero
// - Power-down keeps the address decode enabled
// - Decode disabled only when base below 100h
// - Powered-down valid device still checks conflicts
// - Vendor reg resets 0x70; bits 0,2,3,7 zero
// - Misc reg resets 0x00; bit7 reserved
// - Bits 1:0 select parallel mode
// - Combined mode: ECR 100 selects EPP
// - Extended modes: ECR 000 selects standard
// - Misc bit4 enables port1 music clock
// - Misc bit5 enables port2 music clock
// - Music clock runs 31.25 kbaud within 1%
// - Misc bit6 picks EPP revision 1.7/1.9
// - Printer-mode bit high forces printer mode
// - Cleared lock blocks access until reset
//
// The Avalon-MM register port is this design's own decision.
module sppm_config (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Hard reset pin, asynchronous to clk
    input wire logic hardRstPin,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Extended control register mode from the parallel port
    input wire logic [2:0] ecrMode,
    // Serial port controls
    output logic port1PowerOn,
    output logic port2PowerOn,
    output logic firPowerOn,
    output logic port1MusicTick,
    output logic port2MusicTick,
    // Host decode and conflict checking
    output logic port1DecodeEnable,
    output logic port2DecodeEnable,
    output logic port1RangeCheck,
    output logic port2RangeCheck,
    // Parallel port mode
    output sppm_pkg::sppm_par_mode_t parMode,
    output logic eppSelected,
    output logic sppSelected,
    output logic eppRevision17
);
    logic [7:0] configSelectIndex;
    logic [7:0] serialPortPower;
    logic [7:0] vendorReservedThree;
    logic [7:0] parallelSerialMisc;
    logic [7:0] lockModeRegister;
    logic cfgActive;
    logic [15:0] port1Base;
    logic [15:0] port2Base;
    logic [2:0] hardSync;
    logic hardReset;
    logic ack;
    logic accessReq;
    logic takeWrite;
    logic winOpen;
    logic [7:0] winData;
    logic [31:0] next_readdata;
    logic [31:0] statusWord;
    logic [1:0] musicEnable;
    logic [1:0] musicTick;

    // Byte-lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    // Masked byte write: only writable positions change
    function automatic logic [7:0] maskWrite(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] mask);
        return (old & ~mask) | (wd & mask);
    endfunction : maskWrite

    // Hard reset pin passes three flops; level changes only once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            hardSync <= 3'h0;
            hardReset <= 1'b0;
        end else begin
            hardSync <= {hardSync[1:0], hardRstPin};
            if (hardSync[1] == hardSync[2]) begin
                hardReset <= hardSync[2];
            end
        end
    end

    // One wait state per access so read data can be registered
    assign accessReq = read | write;
    assign waitrequest = accessReq & ~ack;
    assign takeWrite = write & ack;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= accessReq & ~ack;
        end
    end

    // Window into the indexed bank opens only in config state and while unlocked
    assign winOpen = cfgActive & lockModeRegister[sppm_pkg::BIT_LOCK];

    // Indexed read decode; unused positions return zero
    always_comb begin
        winData = 8'h00;
        if (winOpen) begin
            unique case (configSelectIndex)
                sppm_pkg::IDX_SERIAL_PORT_POWER: begin
                    winData = serialPortPower & sppm_pkg::MASK_SERIAL_PORT_POWER;
                end
                sppm_pkg::IDX_VENDOR_RESERVED_THREE: begin
                    winData = vendorReservedThree & sppm_pkg::MASK_VENDOR_RESERVED_THREE;
                end
                sppm_pkg::IDX_PARALLEL_SERIAL_MISC: begin
                    winData = parallelSerialMisc & sppm_pkg::MASK_PARALLEL_SERIAL_MISC;
                end
                default: begin
                    winData = 8'h00;
                end
            endcase
        end
    end

    // Live status of the serial power, decode, range-check and EPP revision outputs
    assign statusWord = {24'h000000, eppRevision17, port2RangeCheck, port1RangeCheck,
                         port2DecodeEnable, port1DecodeEnable, firPowerOn, port2PowerOn,
                         port1PowerOn};

    // Bus read decode; unmapped addresses read zero
    always_comb begin
        next_readdata = 32'h00000000;
        unique case (address)
            sppm_pkg::ADDR_INDEX: next_readdata = {24'h000000, configSelectIndex};
            sppm_pkg::ADDR_DATA: next_readdata = {24'h000000, winData};
            sppm_pkg::ADDR_CTRL: next_readdata = {31'h00000000, cfgActive};
            sppm_pkg::ADDR_LOCK_MODE: next_readdata = {24'h000000, lockModeRegister};
            sppm_pkg::ADDR_BASE1: next_readdata = {16'h0000, port1Base};
            sppm_pkg::ADDR_BASE2: next_readdata = {16'h0000, port2Base};
            sppm_pkg::ADDR_STATUS: next_readdata = statusWord;
            default: next_readdata = 32'h00000000;
        endcase
    end

    // Read data captured one edge ahead so it stands when waitrequest drops
    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h00000000;
        end else if (read & ~ack) begin
            readdata <= next_readdata;
        end
    end

    // Index and config-state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            configSelectIndex <= 8'h00;
            cfgActive <= 1'b0;
        end else if (takeWrite & byteenable[0]) begin
            if (address == sppm_pkg::ADDR_INDEX) begin
                configSelectIndex <= writedata[7:0];
            end
            if (address == sppm_pkg::ADDR_CTRL) begin
                cfgActive <= writedata[sppm_pkg::BIT_CFG_ACTIVE];
            end
        end
    end

    // Lock/mode register: once the lock is cleared only a reset sets it again
    always_ff @(posedge clk) begin
        if (rst) begin
            lockModeRegister <= sppm_pkg::RST_LOCK_MODE;
        end else if (hardReset) begin
            lockModeRegister[sppm_pkg::BIT_LOCK] <= 1'b1;
        end else if (takeWrite & byteenable[0] & winOpen
                     & (address == sppm_pkg::ADDR_LOCK_MODE)) begin
            lockModeRegister <= maskWrite(lockModeRegister, writedata[7:0],
                                          sppm_pkg::MASK_LOCK_MODE);
        end
    end

    // Serial port power register; hard reset drops the secondary port
    always_ff @(posedge clk) begin
        if (rst) begin
            serialPortPower <= sppm_pkg::RST_SERIAL_PORT_POWER;
        end else if (hardReset) begin
            serialPortPower[sppm_pkg::BIT_PORT2_POWER] <= 1'b0;
        end else if (takeWrite & byteenable[0] & winOpen & (address == sppm_pkg::ADDR_DATA)
                     & (configSelectIndex == sppm_pkg::IDX_SERIAL_PORT_POWER)) begin
            serialPortPower <= maskWrite(serialPortPower, writedata[7:0],
                                         sppm_pkg::MASK_SERIAL_PORT_POWER);
        end
    end

    // Vendor-reserved register; software is expected to write back defaults
    always_ff @(posedge clk) begin
        if (rst) begin
            vendorReservedThree <= sppm_pkg::RST_VENDOR_RESERVED_THREE;
        end else if (takeWrite & byteenable[0] & winOpen & (address == sppm_pkg::ADDR_DATA)
                     & (configSelectIndex == sppm_pkg::IDX_VENDOR_RESERVED_THREE)) begin
            vendorReservedThree <= maskWrite(vendorReservedThree, writedata[7:0],
                                             sppm_pkg::MASK_VENDOR_RESERVED_THREE);
        end
    end

    // Miscellaneous parallel/serial register
    always_ff @(posedge clk) begin
        if (rst) begin
            parallelSerialMisc <= sppm_pkg::RST_PARALLEL_SERIAL_MISC;
        end else if (takeWrite & byteenable[0] & winOpen & (address == sppm_pkg::ADDR_DATA)
                     & (configSelectIndex == sppm_pkg::IDX_PARALLEL_SERIAL_MISC)) begin
            parallelSerialMisc <= maskWrite(parallelSerialMisc, writedata[7:0],
                                            sppm_pkg::MASK_PARALLEL_SERIAL_MISC);
        end
    end

    // Base addresses, held here so decode can follow them
    always_ff @(posedge clk) begin
        if (rst) begin
            port1Base <= sppm_pkg::RST_BASE;
            port2Base <= sppm_pkg::RST_BASE;
        end else if (takeWrite & winOpen) begin
            if (address == sppm_pkg::ADDR_BASE1) begin
                port1Base <= merge16(port1Base, writedata, byteenable);
            end
            if (address == sppm_pkg::ADDR_BASE2) begin
                port2Base <= merge16(port2Base, writedata, byteenable);
            end
        end
    end

    // Power and decode outputs; decode ignores power on purpose
    always_ff @(posedge clk) begin
        if (rst) begin
            port1PowerOn <= 1'b0;
            port2PowerOn <= 1'b0;
            firPowerOn <= 1'b0;
            port1DecodeEnable <= 1'b0;
            port2DecodeEnable <= 1'b0;
            port1RangeCheck <= 1'b0;
            port2RangeCheck <= 1'b0;
        end else begin
            port1PowerOn <= serialPortPower[sppm_pkg::BIT_PORT1_POWER];
            port2PowerOn <= serialPortPower[sppm_pkg::BIT_PORT2_POWER];
            firPowerOn <= serialPortPower[sppm_pkg::BIT_PORT2_POWER];
            port1DecodeEnable <= port1Base >= sppm_pkg::MIN_DECODE_BASE;
            port2DecodeEnable <= port2Base >= sppm_pkg::MIN_DECODE_BASE;
            port1RangeCheck <= port1Base >= sppm_pkg::MIN_DECODE_BASE;
            port2RangeCheck <= port2Base >= sppm_pkg::MIN_DECODE_BASE;
        end
    end

    // Parallel mode; printer-mode bit overrides the extended selection
    always_ff @(posedge clk) begin
        if (rst) begin
            parMode <= sppm_pkg::PAR_PRINTER;
            eppSelected <= 1'b0;
            sppSelected <= 1'b0;
            eppRevision17 <= 1'b0;
        end else begin
            eppRevision17 <= parallelSerialMisc[sppm_pkg::BIT_EPP_REVISION];
            if (lockModeRegister[sppm_pkg::BIT_PRINTER_MODE]) begin
                parMode <= sppm_pkg::PAR_PRINTER;
                eppSelected <= 1'b0;
                sppSelected <= 1'b1;
            end else begin
                unique case (parallelSerialMisc[1:0])
                    2'h0: begin
                        parMode <= sppm_pkg::PAR_SPP;
                        eppSelected <= 1'b0;
                        sppSelected <= 1'b1;
                    end
                    2'h1: begin
                        parMode <= sppm_pkg::PAR_EPP_SPP;
                        eppSelected <= 1'b1;
                        sppSelected <= 1'b1;
                    end
                    2'h2: begin
                        parMode <= sppm_pkg::PAR_ECP;
                        eppSelected <= 1'b0;
                        sppSelected <= ecrMode == sppm_pkg::ECR_MODE_SPP;
                    end
                    2'h3: begin
                        parMode <= sppm_pkg::PAR_ECP_EPP;
                        eppSelected <= ecrMode == sppm_pkg::ECR_MODE_EPP;
                        sppSelected <= ecrMode == sppm_pkg::ECR_MODE_SPP;
                    end
                endcase
            end
        end
    end

    // Music clock ticks at 16x 31.25 kbaud; 50 MHz divides exactly, so no drift
    assign musicEnable = {parallelSerialMisc[sppm_pkg::BIT_PORT2_MUSIC],
                          parallelSerialMisc[sppm_pkg::BIT_PORT1_MUSIC]};

    for (genvar g = 0; g < 2; g++) begin : gMusic
        logic [7:0] divCount;
        always_ff @(posedge clk) begin
            if (rst || !musicEnable[g]) begin
                divCount <= 8'h00;
                musicTick[g] <= 1'b0;
            end else if (divCount == 8'(sppm_pkg::MUSIC_TICK_CYCLES - 1)) begin
                divCount <= 8'h00;
                musicTick[g] <= 1'b1;
            end else begin
                divCount <= divCount + 8'h01;
                musicTick[g] <= 1'b0;
            end
        end
    end

    assign port1MusicTick = musicTick[0];
    assign port2MusicTick = musicTick[1];
endmodule : sppm_config

/* sim/sppm_config_props.sv */
// Concurrent checks on the ports of the configuration bank
module sppm_config_props (
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic hardRstPin,
    // Avalon-MM slave
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Parallel port mode inputs and outputs
    input wire logic [2:0] ecrMode,
    input wire sppm_pkg::sppm_par_mode_t parMode,
    input wire logic eppSelected,
    input wire logic sppSelected,
    // Serial port controls and decode
    input wire logic port1PowerOn,
    input wire logic port2PowerOn,
    input wire logic firPowerOn,
    input wire logic port1MusicTick,
    input wire logic port1DecodeEnable,
    input wire logic port2DecodeEnable,
    input wire logic port1RangeCheck,
    input wire logic port2RangeCheck
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Bus answers after exactly one wait cycle; read data holds between reads
    property p_wait;
        $rose(read || write) |-> waitrequest ##1 !waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("access not answered after one wait");
    property p_hold;
        !read |=> $stable(readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    // Outputs follow the power-on values one edge after release
    property p_por;
        $fell(rst) |=> port1PowerOn && !port2PowerOn && sppSelected
            && parMode == sppm_pkg::PAR_PRINTER;
    endproperty
    a_por: assert property (p_por) else $error("power-on values wrong");
    property p_hard;
        hardRstPin [*7] |-> !port2PowerOn && !firPowerOn;
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset left port2 powered");
    property p_fir;
        port2PowerOn == firPowerOn;
    endproperty
    a_fir: assert property (p_fir) else $error("infrared power differs from port2");
    property p_range;
        port1RangeCheck == port1DecodeEnable && port2RangeCheck == port2DecodeEnable;
    endproperty
    a_range: assert property (p_range) else $error("range check differs from decode");
    property p_tick;
        port1MusicTick |=> (!port1MusicTick) [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("music ticks too close");
    property p_prn;
        !$past(rst) && parMode == sppm_pkg::PAR_PRINTER |-> sppSelected && !eppSelected;
    endproperty
    a_prn: assert property (p_prn) else $error("printer mode selects wrong port");
    property p_epp01;
        !$past(rst) && parMode == sppm_pkg::PAR_EPP_SPP |-> eppSelected && sppSelected;
    endproperty
    a_epp01: assert property (p_epp01) else $error("mode 01 selects wrong port");
    property p_ecpepp;
        (parMode == sppm_pkg::PAR_ECP_EPP && ecrMode == sppm_pkg::ECR_MODE_EPP) [*2]
            |-> eppSelected && !sppSelected;
    endproperty
    a_ecpepp: assert property (p_ecpepp) else $error("control mode 100 not EPP");
    property p_ecpspp;
        (parMode inside {sppm_pkg::PAR_ECP, sppm_pkg::PAR_ECP_EPP}
            && ecrMode == sppm_pkg::ECR_MODE_SPP) [*2] |-> sppSelected && !eppSelected;
    endproperty
    a_ecpspp: assert property (p_ecpspp) else $error("control mode 000 not standard");

    // Main scenarios reached
    c_tick: cover property (port1MusicTick);
    c_epp: cover property (eppSelected && parMode == sppm_pkg::PAR_ECP_EPP);
    c_hard: cover property (hardRstPin [*7]);
    c_write: cover property (write && !waitrequest);
endmodule : sppm_config_props

/* sim/sppm_host_model.sv */
// Host software model: an Avalon-MM master reaching the indexed bank
module sppm_host_model (
    // Clock
    input wire logic clk,
    // Avalon-MM master
    output logic [4:0] address,
    output logic read,
    output logic write,
    output logic [3:0] byteenable,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero; all lanes enabled since the bank is narrow
    initial begin
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = 32'h00000000;
    end

    // One access, held until waitrequest is sampled low; bounded so a hang is caught
    task automatic bus_cycle(input logic [4:0] a, input logic wr, input logic [31:0] wd,
                             output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        ok = (n < 50);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_cycle

    // Index then data; vendor-owned fields always go out at their defaults
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val, output logic ok);
        logic [7:0] v;
        logic [31:0] d;
        logic ok1;
        v = val;
        if (idx == sppm_pkg::IDX_VENDOR_RESERVED_THREE) v = 8'h70 | (val & 8'h8D);
        if (idx == sppm_pkg::IDX_PARALLEL_SERIAL_MISC) v = val & 8'hF3;
        bus_cycle(sppm_pkg::ADDR_INDEX, 1'b1, {24'h000000, idx}, d, ok1);
        bus_cycle(sppm_pkg::ADDR_DATA, 1'b1, {24'h000000, v}, d, ok);
        ok = ok & ok1;
    endtask : cfg_write

    // Index then data read
    task automatic cfg_read(input logic [7:0] idx, output logic [31:0] d, output logic ok);
        logic ok1;
        bus_cycle(sppm_pkg::ADDR_INDEX, 1'b1, {24'h000000, idx}, d, ok1);
        bus_cycle(sppm_pkg::ADDR_DATA, 1'b0, 32'h00000000, d, ok);
        ok = ok & ok1;
    endtask : cfg_read
endmodule : sppm_host_model

/* sim/test_sppm_config.sv */
// Self-checking bench for the configuration bank
module test_sppm_config;
    timeunit 1ns;
    timeprecision 1ps;
    // Row: index, value written, control mode, readback, {p1,p2,mode,epp,spp,rev17}
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] val;
        logic [2:0] ecr;
        logic [7:0] rd;
        logic [7:0] outs;
    } sppm_row_t;
    localparam sppm_row_t ROWS [11] = '{
        '{8'h02, 8'hFF, 3'h0, 8'h88, 8'hCA}, '{8'h02, 8'h77, 3'h0, 8'h00, 8'h0A},
        '{8'h02, 8'h80, 3'h0, 8'h80, 8'h4A}, '{8'h04, 8'h01, 3'h0, 8'h01, 8'h56},
        '{8'h04, 8'h02, 3'h0, 8'h02, 8'h5A}, '{8'h04, 8'h02, 3'h4, 8'h02, 8'h58},
        '{8'h04, 8'h03, 3'h4, 8'h03, 8'h64}, '{8'h04, 8'h03, 3'h0, 8'h03, 8'h62},
        '{8'h04, 8'hFF, 3'h0, 8'h73, 8'h63}, '{8'h04, 8'h40, 3'h0, 8'h40, 8'h4B},
        '{8'h03, 8'hFF, 3'h0, 8'h70, 8'h4B}};
    // Music tick spacing from 31.25 kbaud with 16x oversampling at 50 MHz
    localparam int TICK_GAP = 50000000 / (31250 * 16);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hardRstPin = 1'b0;
    logic [2:0] ecrMode = 3'h0;
    logic [4:0] address;
    logic read, write, waitrequest;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, d;
    logic port1PowerOn, port2PowerOn, firPowerOn, port1MusicTick, port2MusicTick;
    logic port1DecodeEnable, port2DecodeEnable, port1RangeCheck, port2RangeCheck;
    logic eppSelected, sppSelected, eppRevision17;
    sppm_pkg::sppm_par_mode_t parMode;
    int errCount = 0;
    int testsRun = 0;
    int g;
    logic ok;

    sppm_config i_dut (.clk, .rst, .hardRstPin, .address, .read, .write, .byteenable,
        .writedata, .readdata, .waitrequest, .ecrMode, .port1PowerOn, .port2PowerOn,
        .firPowerOn, .port1MusicTick, .port2MusicTick, .port1DecodeEnable,
        .port2DecodeEnable, .port1RangeCheck, .port2RangeCheck, .parMode, .eppSelected,
        .sppSelected, .eppRevision17);
    sppm_host_model i_host (.clk, .address, .read, .write, .byteenable, .writedata, .readdata,
        .waitrequest);

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            errCount++;
        end
    endtask : chk
    // A stuck bus counts as a mismatch and ends the run
    task automatic bus_ok(input logic ok);
        if (ok !== 1'b1) begin
            chk("bus answer", 32'h1, 32'h0);
            test_done();
        end
    endtask : bus_ok
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        i_host.bus_cycle(a, 1'b1, v, d, ok);
        bus_ok(ok);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        i_host.bus_cycle(a, 1'b0, 32'h0, d, ok);
        bus_ok(ok);
    endtask : rd
    task automatic cw(input logic [7:0] idx, input logic [7:0] v);
        i_host.cfg_write(idx, v, ok);
        bus_ok(ok);
    endtask : cw
    task automatic cr(input logic [7:0] idx);
        i_host.cfg_read(idx, d, ok);
        bus_ok(ok);
    endtask : cr
    // Cycles between two ticks of one port, 0 when no second tick comes
    task automatic tick_gap(input logic sel, output int gap);
        int n;
        int seen;
        n = 0;
        seen = 0;
        gap = 0;
        while (seen < 2 && n < 400) begin
            @(negedge clk);
            n++;
            if ((sel ? port2MusicTick : port1MusicTick) === 1'b1) begin
                seen++;
                if (seen == 2) gap = n;
                n = 0;
            end
        end
    endtask : tick_gap

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk("por outs", 32'h9, {port1PowerOn, port2PowerOn, firPowerOn, sppSelected});
        chk("por mode", sppm_pkg::PAR_PRINTER, parMode);
        cr(8'h02);
        chk("closed window", 32'h0, d);
        wr(5'h1C, 32'hFFFFFFFF);
        rd(5'h1C);
        chk("unmapped", 32'h0, d);
        wr(sppm_pkg::ADDR_CTRL, 32'h1);
        cr(8'h02);
        chk("power por", 32'h08, d);
        cr(8'h03);
        chk("vendor por", 32'h70, d);
        cr(8'h04);
        chk("misc por", 32'h00, d);
        cr(8'h05);
        chk("other index", 32'h0, d);
        wr(sppm_pkg::ADDR_LOCK_MODE, 32'h80);
        $display("test reset done");
        // Table of register writes and the port levels they give
        foreach (ROWS[i]) begin
            @(posedge clk);
            ecrMode <= ROWS[i].ecr;
            cw(ROWS[i].idx, ROWS[i].val);
            cr(ROWS[i].idx);
            chk("readback", {24'h0, ROWS[i].rd}, d);
            repeat (2) @(negedge clk);
            chk("outputs", {24'h0, ROWS[i].outs}, {port1PowerOn, port2PowerOn, parMode,
                eppSelected, sppSelected, eppRevision17});
        end
        $display("test table done");
        cw(8'h04, 8'h30);
        tick_gap(1'b0, g);
        chk("tick1 gap", TICK_GAP, g);
        tick_gap(1'b1, g);
        chk("tick2 gap", TICK_GAP, g);
        cw(8'h04, 8'h00);
        tick_gap(1'b0, g);
        chk("tick off", 32'h0, g);
        $display("test music done");
        wr(sppm_pkg::ADDR_BASE1, 32'h00FF);
        repeat (2) @(negedge clk);
        chk("low base", 32'h0, {port1DecodeEnable, port1RangeCheck});
        wr(sppm_pkg::ADDR_BASE1, 32'h0100);
        wr(sppm_pkg::ADDR_BASE2, 32'h03F8);
        cw(8'h02, 8'h00);
        repeat (2) @(negedge clk);
        chk("decode", 32'h3, {port1PowerOn, port2PowerOn,
            port1DecodeEnable, port2DecodeEnable});
        rd(sppm_pkg::ADDR_STATUS);
        chk("status", 32'h78, d);
        $display("test decode done");
        cw(8'h02, 8'h88);
        wr(sppm_pkg::ADDR_LOCK_MODE, 32'h0);
        cw(8'h02, 8'h00);
        cr(8'h02);
        chk("locked read", 32'h0, d);
        chk("locked write", 32'h3, {port1PowerOn, port2PowerOn});
        hardRstPin <= 1'b1;
        repeat (8) @(posedge clk);
        hardRstPin <= 1'b0;
        repeat (4) @(negedge clk);
        chk("hard reset", 32'h2, {port1PowerOn, port2PowerOn});
        @(posedge clk);
        cr(8'h02);
        chk("after hard", 32'h08, d);
        $display("test lock done");
        test_done();
    end
endmodule : test_sppm_config

bind sppm_config sppm_config_props i_props (.clk, .rst, .hardRstPin, .read, .write, .readdata,
    .waitrequest, .ecrMode, .parMode, .eppSelected, .sppSelected, .port1PowerOn,
    .port2PowerOn, .firPowerOn, .port1MusicTick, .port1DecodeEnable, .port2DecodeEnable,
    .port1RangeCheck, .port2RangeCheck);
